/* File: pwm_timer_output_control.sv */
// Control logic of a 10-bit PWM timer: clock select and prescaler, counter,
// compare-output waveforms for channels A, B and D, force, inversion, dead-time tick.
// Assumes the fast peripheral clock arrives as a one-cycle enable in this domain.
//
// Functional notes
// - Force A in non-PWM mode applies channel A match action, no interrupt.
// - Force B in non-PWM mode applies channel B match action, no interrupt.
// - Force A uses channel A mode bits written in the same cycle.
// - Force B uses channel B mode bits written in the same cycle.
// - Force bits always read back as zero.
// - PWM enable bit puts its channel into PWM operation on its compare value.
// - Inversion bit inverts both true and complementary outputs.
// - Prescaler clear resets prescaler, leaves counter, self-clears, reads zero.
// - Dead-time prescaler divides timer clock by 1, 2, 4 or 8.
// - Clock select 0 stops; code n divides chosen source by 2^(n-1).
// - Control C top four bits are read/write shadows of A and B modes.
// - Nonzero channel D mode takes over the channel D pin.
// - Complementary D pin connects only in PWM modes with mode 01.
// - Channel D mode meaning depends on its PWM enable and wavegen low bit.
// - Non-PWM D: 01 toggle, 10 clear, 11 set on match; true pin only.
// - Fast PWM D: 01/10 clear on match, set at zero; 11 reversed.
// - Dual-slope D: 01/10 clear on up match, set on down; 11 reversed.
// - PWM clear means normal mode; wavegen low bit chooses fast or dual-slope.
// - Counter is a 10-bit up/down counter, software readable and writable.
`default_nettype none
module pwm_timer_output_control #(
  parameter int PRESCALE_W = 14
) (
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_b_i,
  // Register port
  input  wire pwm_timer_pkg::bus_req_type  bus_i,
  output logic                       [7:0] rdata_o,
  // Timer clock source
  input  wire logic                        async_mode_i,
  input  wire logic                        fast_tick_i,
  // Waveform outputs, index 0 = A, 1 = B, 2 = D
  output logic                       [2:0] compare_pin_o,
  output logic                       [2:0] compare_pin_n_o,
  output logic                       [2:0] pin_connect_o,
  output logic                       [2:0] pin_n_connect_o,
  // Timing strobes
  output logic                             timer_tick_o,
  output logic                             deadtime_tick_o
);
  import pwm_timer_pkg::*;

  if (PRESCALE_W < 14) begin : g_width_check
    $error("PRESCALE_W must be at least 14 to reach divide by 16384");
  end

  // ==========================================================================
  // Registers
  logic [1:0]            outmode [3];
  logic [2:0]            pwm_enable;
  logic [1:0]            wavegen;
  logic                  pwm_output_invert;
  logic [1:0]            deadtime_div;
  logic [3:0]            clk_select;
  logic [9:0]            count_value;
  logic                  count_down;
  logic [9:0]            compare_value [3];
  logic [9:0]            top_value;
  logic [1:0]            high_temp;
  logic [PRESCALE_W-1:0] prescaler;
  logic [2:0]            deadtime_cnt;
  logic [2:0]            waveform;

  // ==========================================================================
  // Address decode
  wire wr_a     = bus_i.wr && (bus_i.addr == CTRL_A_OFS);
  wire wr_b     = bus_i.wr && (bus_i.addr == CTRL_B_OFS);
  wire wr_c     = bus_i.wr && (bus_i.addr == CTRL_C_OFS);
  wire wr_wg    = bus_i.wr && (bus_i.addr == WAVEGEN_OFS);
  wire wr_count = bus_i.wr && (bus_i.addr == COUNT_OFS);
  wire wr_high  = bus_i.wr && (bus_i.addr == HIGH_OFS);
  wire wr_top   = bus_i.wr && (bus_i.addr == TOP_OFS);
  wire rd_count = bus_i.rd && (bus_i.addr == COUNT_OFS);
  wire [2:0] wr_cmp = {bus_i.wr && (bus_i.addr == CMP_D_OFS),
                       bus_i.wr && (bus_i.addr == CMP_B_OFS),
                       bus_i.wr && (bus_i.addr == CMP_A_OFS)};
  wire [9:0] wide_wdata = {high_temp, bus_i.wdata};
  wire [1:0] wd_mode_a  = bus_i.wdata[MODE_HI_POS -: 2];
  wire [1:0] wd_mode_b  = bus_i.wdata[MODE_B_POS -: 2];

  // Mode fields seen by this cycle's force: freshly written bits win
  logic [1:0] eff_mode [3];
  assign eff_mode[0] = (wr_a || wr_c) ? wd_mode_a : outmode[0];
  assign eff_mode[1] = (wr_a || wr_c) ? wd_mode_b : outmode[1];
  assign eff_mode[2] = wr_c ? bus_i.wdata[MODE_D_POS -: 2] : outmode[2];
  wire [2:0] force_strobe = {wr_c && bus_i.wdata[FORCE_D_POS],
                             wr_a && bus_i.wdata[FORCE_B_POS],
                             wr_a && bus_i.wdata[FORCE_A_POS]};
  wire psc_clear = wr_b && bus_i.wdata[PSC_CLEAR_POS];

  // ==========================================================================
  // Clock select and prescaler
  wire base_tick = async_mode_i ? fast_tick_i : 1'b1;
  wire [PRESCALE_W-1:0] div_mask = (clk_select == CLK_STOP) ? '0 :
    PRESCALE_W'((PRESCALE_W'(1) << (clk_select - 4'h1)) - PRESCALE_W'(1));
  wire timer_tick = (clk_select != CLK_STOP) && base_tick && !psc_clear &&
                    ((prescaler & div_mask) == div_mask);

  // Prescaler only advances while the timer runs; a clear restarts the phase
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || psc_clear) begin
      prescaler <= '0;
    end else if (clk_select != CLK_STOP && base_tick) begin
      prescaler <= prescaler + PRESCALE_W'(1);
    end
  end

  // Dead-time prescaler: every 1, 2, 4 or 8 timer ticks
  wire [2:0] dt_mask  = 3'((4'h1 << deadtime_div) - 4'h1);
  wire       dt_tick  = timer_tick && ((deadtime_cnt & dt_mask) == dt_mask);
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      deadtime_cnt <= '0;
    end else if (timer_tick) begin
      deadtime_cnt <= deadtime_cnt + 3'h1;
    end
  end

  // ==========================================================================
  // Counter; dual slope when any channel is in PWM with wavegen low bit set
  wire any_pwm   = |pwm_enable;
  wire dual      = any_pwm && wavegen[0];
  wire run       = timer_tick && !wr_count;
  wire at_bottom = (count_value == COUNT_BOTTOM);
  logic [9:0] next_count;
  logic       next_down;
  always_comb begin
    next_count = count_value;
    next_down  = count_down;
    if (wr_count) begin
      next_count = wide_wdata;
      next_down  = 1'b0;
    end else if (run && dual) begin
      if (!count_down && count_value >= top_value) begin
        next_down  = 1'b1;
        next_count = count_value - 10'h001;
      end else if (count_down && at_bottom) begin
        next_down  = 1'b0;
        next_count = count_value + 10'h001;
      end else begin
        next_count = count_down ? count_value - 10'h001 : count_value + 10'h001;
      end
    end else if (run) begin
      next_down  = 1'b0;
      next_count = (count_value >= top_value) ? COUNT_BOTTOM : count_value + 10'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      count_value <= COUNT_BOTTOM;
      count_down  <= 1'b0;
    end else begin
      count_value <= next_count;
      count_down  <= next_down;
    end
  end

  // ==========================================================================
  // Per-channel waveform logic
  logic [2:0] next_wave;
  for (genvar ch = 0; ch < 3; ch++) begin : g_chan
    wire [1:0] m       = eff_mode[ch];
    wire       match   = run && (count_value == compare_value[ch]);
    wire       set_val = (m == MODE_SET);
    always_comb begin
      next_wave[ch] = waveform[ch];
      if (!pwm_enable[ch]) begin
        if (match || force_strobe[ch]) begin
          case (m)
            MODE_TOGGLE: next_wave[ch] = !waveform[ch];
            MODE_CLEAR:  next_wave[ch] = 1'b0;
            MODE_SET:    next_wave[ch] = 1'b1;
            default:     next_wave[ch] = waveform[ch];
          endcase
        end
      end else if (m != MODE_OFF && wavegen[0]) begin
        if (match) begin
          next_wave[ch] = count_down ? !set_val : set_val;
        end
      end else if (m != MODE_OFF) begin
        if (run && at_bottom) begin
          next_wave[ch] = !set_val;
        end else if (match) begin
          next_wave[ch] = set_val;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      waveform <= '0;
    end else begin
      waveform <= next_wave;
    end
  end

  // Pin stage: registered so the pins never glitch on mode writes
  logic [2:0] true_conn;
  logic [2:0] comp_conn;
  for (genvar ch = 0; ch < 3; ch++) begin : g_conn
    assign true_conn[ch] = (outmode[ch] != MODE_OFF);
    assign comp_conn[ch] = pwm_enable[ch] && (outmode[ch] == MODE_TOGGLE);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      compare_pin_o   <= '0;
      compare_pin_n_o <= '0;
      pin_connect_o   <= '0;
      pin_n_connect_o <= '0;
      timer_tick_o    <= 1'b0;
      deadtime_tick_o <= 1'b0;
    end else begin
      compare_pin_o   <= waveform ^ {3{pwm_output_invert}};
      compare_pin_n_o <= ~waveform ^ {3{pwm_output_invert}};
      pin_connect_o   <= true_conn;
      pin_n_connect_o <= comp_conn;
      timer_tick_o    <= timer_tick;
      deadtime_tick_o <= dt_tick;
    end
  end

  // ==========================================================================
  // Register writes; force and prescaler-clear bits are never stored
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      outmode           <= '{default: MODE_OFF};
      pwm_enable        <= '0;
      wavegen           <= '0;
      pwm_output_invert <= 1'b0;
      deadtime_div      <= '0;
      clk_select        <= CLK_STOP;
      top_value         <= TOP_RESET;
      compare_value     <= '{default: COUNT_BOTTOM};
    end else begin
      if (wr_a || wr_c) begin
        outmode[0] <= wd_mode_a;
        outmode[1] <= wd_mode_b;
      end
      if (wr_a) begin
        pwm_enable[0] <= bus_i.wdata[PWM_A_POS];
        pwm_enable[1] <= bus_i.wdata[PWM_B_POS];
      end
      if (wr_c) begin
        outmode[2]    <= bus_i.wdata[MODE_D_POS -: 2];
        pwm_enable[2] <= bus_i.wdata[PWM_D_POS];
      end
      if (wr_b) begin
        pwm_output_invert <= bus_i.wdata[INVERT_POS];
        deadtime_div      <= bus_i.wdata[DT_DIV_POS -: 2];
        clk_select        <= bus_i.wdata[CLK_SEL_POS -: 4];
      end
      if (wr_wg) begin
        wavegen <= bus_i.wdata[1:0];
      end
      if (wr_top) begin
        top_value <= wide_wdata;
      end
      for (int ch = 0; ch < 3; ch++) begin
        if (wr_cmp[ch]) begin
          compare_value[ch] <= wide_wdata;
        end
      end
    end
  end

  // Shared high byte: written by software, loaded by a count read
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      high_temp <= '0;
    end else if (wr_high) begin
      high_temp <= bus_i.wdata[1:0];
    end else if (rd_count) begin
      high_temp <= count_value[9:8];
    end
  end

  // ==========================================================================
  // Read mux; unmapped addresses read zero
  wire [7:0] rd_ctrl_a = {outmode[0], outmode[1], 2'b00, pwm_enable[0], pwm_enable[1]};
  wire [7:0] rd_ctrl_b = {pwm_output_invert, 1'b0, deadtime_div, clk_select};
  wire [7:0] rd_ctrl_c = {outmode[0], outmode[1], outmode[2], 1'b0, pwm_enable[2]};
  wire [7:0] rd_value =
    (bus_i.addr == CTRL_A_OFS)  ? rd_ctrl_a :
    (bus_i.addr == CTRL_B_OFS)  ? rd_ctrl_b :
    (bus_i.addr == CTRL_C_OFS)  ? rd_ctrl_c :
    (bus_i.addr == WAVEGEN_OFS) ? {6'h00, wavegen} :
    (bus_i.addr == COUNT_OFS)   ? count_value[7:0] :
    (bus_i.addr == HIGH_OFS)    ? {6'h00, high_temp} :
    (bus_i.addr == CMP_A_OFS)   ? compare_value[0][7:0] :
    (bus_i.addr == CMP_B_OFS)   ? compare_value[1][7:0] :
    (bus_i.addr == CMP_D_OFS)   ? compare_value[2][7:0] :
    (bus_i.addr == TOP_OFS)     ? top_value[7:0] : 8'h00;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rdata_o <= 8'h00;
    end else if (bus_i.rd) begin
      rdata_o <= rd_value;
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // ==========================================================================
  // Assertions
  property p_force_reads_zero;
    @(posedge clk_i) disable iff (!rst_b_i)
      (bus_i.rd && bus_i.addr == CTRL_A_OFS) |=> (rdata_o[3:2] == 2'b00);
  endproperty
  a_force_reads_zero: assert property (p_force_reads_zero)
    else $error("force bits read back nonzero");

  property p_force_toggle_a;
    @(posedge clk_i) disable iff (!rst_b_i)
      (wr_a && bus_i.wdata[FORCE_A_POS] && wd_mode_a == MODE_TOGGLE &&
       !bus_i.wdata[PWM_A_POS] && !pwm_enable[0] && !timer_tick)
      |=> (waveform[0] != $past(waveform[0]));
  endproperty
  a_force_toggle_a: assert property (p_force_toggle_a)
    else $error("force on channel A did not toggle");

  property p_force_new_mode_b;
    @(posedge clk_i) disable iff (!rst_b_i)
      (wr_a && bus_i.wdata[FORCE_B_POS] && wd_mode_b == MODE_SET && !pwm_enable[1])
      |=> waveform[1] ##1 compare_pin_o[1] == !pwm_output_invert;
  endproperty
  a_force_new_mode_b: assert property (p_force_new_mode_b)
    else $error("force on channel B ignored freshly written mode");

  property p_force_new_mode_a;
    @(posedge clk_i) disable iff (!rst_b_i)
      (wr_a && bus_i.wdata[FORCE_A_POS] && wd_mode_a == MODE_CLEAR && !pwm_enable[0])
      |=> !waveform[0];
  endproperty
  a_force_new_mode_a: assert property (p_force_new_mode_a)
    else $error("force on channel A ignored freshly written mode");

  property p_invert;
    @(posedge clk_i) disable iff (!rst_b_i)
      rst_b_i |=> (compare_pin_o == ($past(waveform) ^ {3{$past(pwm_output_invert)}})) &&
          (compare_pin_n_o == ~compare_pin_o);
  endproperty
  a_invert: assert property (p_invert)
    else $error("pin polarity does not follow inversion bit");

  property p_psc_clear;
    @(posedge clk_i) disable iff (!rst_b_i)
      psc_clear |=> (prescaler == '0) && (count_value == $past(next_count));
  endproperty
  a_psc_clear: assert property (p_psc_clear)
    else $error("prescaler clear failed");

  property p_stopped;
    @(posedge clk_i) disable iff (!rst_b_i)
      (clk_select == CLK_STOP && !wr_count) |=> $stable(count_value);
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("counter moved while stopped");

  property p_comp_connect;
    @(posedge clk_i) disable iff (!rst_b_i)
      ##1 pin_n_connect_o[2] == ($past(pwm_enable[2]) && $past(outmode[2]) == MODE_TOGGLE);
  endproperty
  a_comp_connect: assert property (p_comp_connect)
    else $error("complementary D pin connection wrong");

  property p_d_override;
    @(posedge clk_i) disable iff (!rst_b_i)
      ##1 pin_connect_o[2] == ($past(outmode[2]) != MODE_OFF);
  endproperty
  a_d_override: assert property (p_d_override)
    else $error("D pin override wrong");

  property p_d_clear_match;
    @(posedge clk_i) disable iff (!rst_b_i)
      (g_chan[2].match && !pwm_enable[2] && eff_mode[2] == MODE_CLEAR) |=> !waveform[2];
  endproperty
  a_d_clear_match: assert property (p_d_clear_match)
    else $error("D clear on match failed");
endmodule : pwm_timer_output_control
`default_nettype wire

/* File: pwm_timer_pkg.sv */
// Shared constants and types for the 10-bit PWM timer output control block.
// Assumes one 100 MHz clock and an 8-bit register port with a one-cycle read delay.
`default_nettype none
package pwm_timer_pkg;
  // ==========================================================================
  // Register offsets
  localparam logic [7:0] CTRL_A_OFS = 8'h20;
  localparam logic [7:0] CTRL_B_OFS = 8'h21;
  localparam logic [7:0] WAVEGEN_OFS = 8'h22;
  localparam logic [7:0] COUNT_OFS = 8'h23;
  localparam logic [7:0] HIGH_OFS = 8'h24;
  localparam logic [7:0] CMP_A_OFS = 8'h25;
  localparam logic [7:0] CMP_B_OFS = 8'h26;
  localparam logic [7:0] CTRL_C_OFS = 8'h27;
  localparam logic [7:0] CMP_D_OFS = 8'h28;
  localparam logic [7:0] TOP_OFS = 8'h29;
  // ==========================================================================
  // Field positions
  localparam int MODE_HI_POS = 7;   // Channel A mode in control A, shadow in control C
  localparam int MODE_B_POS = 5;    // Channel B mode in control A, shadow in control C
  localparam int MODE_D_POS = 3;    // Channel D mode in control C
  localparam int FORCE_A_POS = 3;
  localparam int FORCE_B_POS = 2;
  localparam int FORCE_D_POS = 1;
  localparam int PWM_A_POS = 1;
  localparam int PWM_B_POS = 0;
  localparam int PWM_D_POS = 0;
  localparam int INVERT_POS = 7;
  localparam int PSC_CLEAR_POS = 6;
  localparam int DT_DIV_POS = 5;
  localparam int CLK_SEL_POS = 3;
  // ==========================================================================
  // Reset values and output-mode codes
  localparam logic [9:0] TOP_RESET = 10'h3FF;
  localparam logic [9:0] COUNT_BOTTOM = 10'h000;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_TOGGLE = 2'h1;
  localparam logic [1:0] MODE_CLEAR = 2'h2;
  localparam logic [1:0] MODE_SET = 2'h3;
  localparam logic [3:0] CLK_STOP = 4'h0;
  // ==========================================================================
  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_type;
endpackage : pwm_timer_pkg
`default_nettype wire

/* File: pwm_stage_model.sv */
// Behavioural power stage sitting on the waveform pins of the PWM timer.
// Assumes registered pins in the clk_i domain and pull-downs on every gate input.
`default_nettype none
module pwm_stage_model (
  // Waveform pins from the timer
  input  wire logic [2:0] pin_i,
  input  wire logic [2:0] pin_n_i,
  input  wire logic [2:0] connect_i,
  input  wire logic [2:0] n_connect_i,
  // Port side of each pin
  input  wire logic [2:0] port_i,
  input  wire logic [2:0] dir_out_i,
  // Gate levels seen by the stage
  output logic      [2:0] gate_o,
  output logic      [2:0] gate_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Pad drivers
  // Driver is on only for an output pin; the pull-down keeps the gate off otherwise
  assign gate_o   = dir_out_i & ((connect_i & pin_i) | (~connect_i & port_i));
  assign gate_n_o = dir_out_i & n_connect_i & pin_n_i;
endmodule : pwm_stage_model
`default_nettype wire

/* File: pwm_timer_output_control_tb_top.sv */
// Self-checking bench for the PWM timer output control block.
// Assumes the package, the design and the stage model are compiled first.
`default_nettype none
module pwm_timer_output_control_tb_top;
  import pwm_timer_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Signals
  logic        clk_i;
  logic        rst_b_i;
  bus_req_type bus;
  logic  [7:0] rdata;
  logic        async_mode;
  logic        fast_tick;
  logic        ft_q;
  logic  [2:0] pin;
  logic  [2:0] pin_n;
  logic  [2:0] conn;
  logic  [2:0] n_conn;
  logic  [2:0] gate;
  logic  [2:0] gate_n;
  logic        ttick;
  logic        dtick;
  logic  [2:0] wf;
  int          n_errors;
  int          n_tests;
  int          cyc;
  // ==========================================================================
  // Design and far side
  pwm_timer_output_control #(.PRESCALE_W(14)) dut_u (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .bus_i(bus), .rdata_o(rdata),
    .async_mode_i(async_mode), .fast_tick_i(fast_tick),
    .compare_pin_o(pin), .compare_pin_n_o(pin_n), .pin_connect_o(conn),
    .pin_n_connect_o(n_conn), .timer_tick_o(ttick), .deadtime_tick_o(dtick));
  pwm_stage_model stage_u (
    .pin_i(pin), .pin_n_i(pin_n), .connect_i(conn), .n_connect_i(n_conn),
    .port_i(3'h0), .dir_out_i(3'h7), .gate_o(gate), .gate_n_o(gate_n));
  // ==========================================================================
  // Clock, random fast ticks and hang guard
  always #5 clk_i = ~clk_i;
  // Keep a copy of the tick the design sampled, so async timing needs no guess
  always @(posedge clk_i) begin
    fast_tick <= 1'($urandom);
    ft_q      <= fast_tick;
    cyc       <= cyc + 1;
    if (cyc == 40000) begin
      n_errors = n_errors + 1;
      $display("ERROR timeout expected done seen hang");
      final_report();
    end
  end
  // ==========================================================================
  // Tasks and expectation functions
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One-cycle write strobe; the design takes it at the edge that lowers it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus.wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    bus.rd <= 1'b0;
    #1;
    chk(what, {8'h00, exp}, {8'h00, rdata});
  endtask : rd_chk
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wait_clk
  // Count cycles with a strobe or level high; sel 0 timer tick, 1 dead-time, 2 gate D
  task automatic count_high(input int sel, input int n, output int hi);
    hi = 0;
    repeat (n) begin
      @(posedge clk_i);
      #1;
      hi += (sel == 0) ? int'(ttick) : (sel == 1) ? int'(dtick) : int'(gate[2]);
    end
  endtask : count_high
  function automatic logic force_next(input logic cur, input logic [1:0] code);
    return (code == MODE_TOGGLE) ? ~cur : (code == MODE_SET);
  endfunction : force_next
  // High cycles of gate D over two periods with top 15: fast 32, dual slope 60
  function automatic int duty(input int wg, input logic [1:0] code, input int c);
    if (code == MODE_OFF) return 0;
    if (wg == 1) return (code == MODE_SET) ? 60 - 4 * c : 4 * c;
    return (code == MODE_SET) ? 32 - 2 * c : 2 * c;
  endfunction : duty
  // ==========================================================================
  // Main sequence
  initial begin
    int         hi;
    logic [1:0] code;
    logic [7:0] cmp;
    void'($urandom(32'hCAE6197A));
    clk_i = 1'b0;
    rst_b_i = 1'b0;
    bus = '0;
    async_mode = 1'b0;
    fast_tick = 1'b0;
    ft_q = 1'b0;
    cyc = 0;
    wf = 3'h0;
    n_errors = 0;
    n_tests = 0;
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1'b1;
    // Shadow bits, force D toggle and force bits reading zero
    rd_chk("ctrl_c_reset", CTRL_C_OFS, 8'h00);
    wr(CTRL_C_OFS, 8'hB6);
    wf[2] = 1'b1;
    rd_chk("ctrl_c", CTRL_C_OFS, 8'hB4);
    rd_chk("ctrl_a_shadow", CTRL_A_OFS, 8'hB0);
    chk("pins_after_c", {10'h0, 3'h7, 3'h0}, {10'h0, conn, n_conn});
    // Forces on every channel with the mode written in the same cycle
    for (int c = 0; c < 3; c++) begin
      for (int k = 0; k < 6; k++) begin
        code = (k < 3) ? 2'(3 - k) : 2'(1 + $urandom % 3);
        wf[c] = force_next(wf[c], code);
        case (c)
          0: wr(CTRL_A_OFS, {code, 2'b00, 4'h8});
          1: wr(CTRL_A_OFS, {2'b00, code, 4'h4});
          default: wr(CTRL_C_OFS, {4'h0, code, 2'b10});
        endcase
        wait_clk(2);
        chk("force_pin", {12'h0, wf[c], ~wf[c], 2'b10},
            {12'h0, pin[c], pin_n[c], conn[c], n_conn[c]});
      end
    end
    // A force while PWM is enabled leaves the waveform alone
    code = wf[0] ? MODE_CLEAR : MODE_SET;
    wr(CTRL_A_OFS, {code, 2'b00, 4'h2});
    wr(CTRL_A_OFS, {code, 2'b00, 4'hA});
    wait_clk(2);
    chk("force_in_pwm", {15'h0, wf[0]}, {15'h0, pin[0]});
    rd_chk("ctrl_a_pwm", CTRL_A_OFS, {code, 6'h02});
    // Inversion flips true and complementary pins
    wr(CTRL_B_OFS, 8'h80);
    wait_clk(2);
    chk("invert", {14'h0, ~wf[0], wf[0]}, {14'h0, pin[0], pin_n[0]});
    rd_chk("ctrl_b_inv", CTRL_B_OFS, 8'h80);
    // Prescaler clear keeps the stopped count and reads zero
    wr(HIGH_OFS, 8'h02);
    wr(COUNT_OFS, 8'hAA);
    wr(CTRL_B_OFS, 8'h40);
    rd_chk("count_lo", COUNT_OFS, 8'hAA);
    rd_chk("count_hi", HIGH_OFS, 8'h02);
    rd_chk("ctrl_b_psc", CTRL_B_OFS, 8'h00);
    // Channel D in non-PWM clear mode while the counter wraps through its compare value
    wr(CTRL_C_OFS, 8'h08);
    // Synchronous clock select: ticks over a whole number of prescaler periods
    for (int n = 0; n < 6; n++) begin
      wr(CTRL_B_OFS, 8'(n));
      wait_clk(4);
      count_high(0, 64, hi);
      chk("timer_ticks", 16'((n == 0) ? 0 : (64 >> (n - 1))), 16'(hi));
    end
    // Dead-time divider on an undivided timer clock
    for (int d = 0; d < 4; d++) begin
      wr(CTRL_B_OFS, {2'b00, 2'(d), 4'h1});
      wait_clk(20);
      count_high(1, 64, hi);
      chk("deadtime_ticks", 16'(64 >> d), 16'(hi));
    end
    // Asynchronous source follows the fast peripheral ticks
    wr(CTRL_B_OFS, 8'h01);
    @(posedge clk_i);
    async_mode <= 1'b1;
    wait_clk(3);
    repeat (40) begin
      @(posedge clk_i);
      #1;
      chk("async_tick", {15'h0, ft_q}, {15'h0, ttick});
    end
    @(posedge clk_i);
    async_mode <= 1'b0;
    // Channel D in fast and dual-slope PWM with a short top
    wr(CTRL_B_OFS, 8'h00);
    wr(HIGH_OFS, 8'h00);
    wr(TOP_OFS, 8'h0F);
    for (int w = 0; w < 2; w++) begin
      for (int m = 0; m < 4; m++) begin
        cmp = 8'(1 + $urandom % 14);
        wr(CTRL_B_OFS, 8'h00);
        wr(COUNT_OFS, 8'h00);
        wr(CMP_D_OFS, cmp);
        wr(WAVEGEN_OFS, 8'(w));
        wr(CTRL_C_OFS, {4'h0, 2'(m), 2'b01});
        wr(CTRL_B_OFS, 8'h01);
        wait_clk(70);
        count_high(2, (w == 1) ? 60 : 32, hi);
        chk("duty_d", 16'(duty(w, 2'(m), int'(cmp))), 16'(hi));
        chk("conn_d", {14'h0, m != 0, m == 1}, {14'h0, conn[2], n_conn[2]});
      end
    end
    final_report();
  end
endmodule : pwm_timer_output_control_tb_top
`default_nettype wire
